// ---- hw/arb_map.svh ----
/*
 Constants for the bus mastership arbiter and external bus release logic.
 Assumes it is included by its bare name by the package and the arbiter module.
*/
// Behaviour
// - Release the external bus only in external extended mode with the enable bit set.
// - Low request pin makes the device drive acknowledge low and float the bus.
// - While released, address, data, selects and all strobes are high impedance.
// - Internal masters keep running internal accesses during release.
// - An external access during release waits until the request is withdrawn.
// - High request pin makes the device drive acknowledge high and resume.
// - Release request wins over a simultaneous internal external access request.
// - Core and transfer controller each request the bus with their own signal.
// - Acknowledge only one master; a free bus goes to the highest-priority requester.
// - A granted master keeps the bus until its acknowledge is withdrawn.
// - Transfer controller outranks the processor core.
// - Internal accesses proceed concurrently with the external bus release.
// - Ownership changes only at points where the current master can yield.
// - Core hands the bus to a requesting transfer controller at its next yield point.
// - Eight-bit two-state spaces use only the upper data byte lanes.
// - Eight-bit two-state accesses have no wait states.
`ifndef ARB_MAP_SVH
`define ARB_MAP_SVH

`define ARB_ADDR_W      24
`define ARB_DATA_W      16
`define ARB_CS_COUNT    8
`define ARB_AREA_MSB    23
`define ARB_AREA_LSB    21
`define ARB_SYNC_STAGES 2
`define ARB_UPPER_MSB   15
`define ARB_UPPER_LSB   8
`define ARB_BE_UPPER    1
`define ARB_BE_LOWER    0

`endif

// ---- hw/arb_pkg.sv ----
/*
 Types for the bus mastership arbiter: bus cycle states and bus owners.
 Assumes arb_map.svh is on the include path.
*/
package arb_pkg;
    `include "arb_map.svh"

    // Gray sequence idle -> T1 -> T2, released sits next to idle
    typedef enum logic [1:0] {
        BUS_IDLE     = 2'b00,
        BUS_T1       = 2'b01,
        BUS_T2       = 2'b11,
        BUS_RELEASED = 2'b10
    } bus_state_t;

    typedef enum logic [1:0] {
        OWN_NONE = 2'b00,
        OWN_CORE = 2'b01,
        OWN_XFER = 2'b11
    } owner_t;
endpackage : arb_pkg

// ---- hw/pin_sync.sv ----
/*
 Two-stage synchroniser for pin inputs, one bit lane per bit of WIDTH.
 Assumes the inputs are asynchronous to clk_sys; RESET_VAL is the idle level.
*/
`timescale 1ns/1ps
module pin_sync
    import arb_pkg::*;
#(
    parameter int                WIDTH     = 1,
    parameter logic [WIDTH-1:0]  RESET_VAL = '0
)(
    // Clock and reset
    input  wire logic             clk_sys,
    input  wire logic             reset_n,
    // Pin side and synchronised side
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t s_r;
    sync_state_t s_nxt;

    // First stage is read only by the second stage
    always_comb
    begin
        s_nxt        = s_r;
        s_nxt.meta   = pin_in;
        s_nxt.stable = s_r.meta;
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            s_r <= '{meta: RESET_VAL, stable: RESET_VAL};
        else
            s_r <= s_nxt;
    end

    assign sync_out = s_r.stable;
endmodule : pin_sync

// ---- hw/bus_mastership_arbiter.sv ----
/*
 Internal bus arbiter for core and transfer controller plus the external
 bus release handshake and a two-state external bus cycle engine.
 Assumes masters hold their request and cycle inputs until answered, and
 that the pad ring resolves each pin from its output enable.
*/
`timescale 1ns/1ps
`include "arb_map.svh"
module bus_mastership_arbiter
    import arb_pkg::*;
(
    // Clock and reset
    input  wire logic                      clk_sys,
    input  wire logic                      reset_n,
    // Static configuration
    input  wire logic                      ext_mode,
    input  wire logic                      release_enable_bit,
    input  wire logic [`ARB_CS_COUNT-1:0]  narrow_area_mask,
    // Internal masters
    input  wire logic                      core_req,
    input  wire logic                      core_yield,
    input  wire logic                      xfer_req,
    input  wire logic                      xfer_yield,
    output logic                           core_ack,
    output logic                           xfer_ack,
    // External cycle request from the owning master
    input  wire logic                      cyc_req,
    input  wire logic                      cyc_write,
    input  wire logic [1:0]                cyc_be,
    input  wire logic [`ARB_ADDR_W-1:0]    cyc_addr,
    input  wire logic [`ARB_DATA_W-1:0]    cyc_wdata,
    output logic                           cyc_done,
    output logic [`ARB_DATA_W-1:0]         cyc_rdata,
    // Release handshake pins
    input  wire logic                      ext_bus_request_n,
    output logic                           ext_bus_ack_n,
    // External bus pins
    output logic [`ARB_ADDR_W-1:0]         addr_out,
    output logic                           addr_oe,
    input  wire logic [`ARB_DATA_W-1:0]    data_in,
    output logic [`ARB_DATA_W-1:0]         data_out,
    output logic                           data_oe,
    output logic [`ARB_CS_COUNT-1:0]       chip_select_n,
    output logic                           address_strobe_n,
    output logic                           read_strobe_n,
    output logic                           upper_write_strobe_n,
    output logic                           lower_write_strobe_n,
    output logic                           ctl_oe
);
    typedef struct packed {
        bus_state_t                 st;
        owner_t                     own;
        logic                       core_ack;
        logic                       xfer_ack;
        logic                       ack_n;
        logic [`ARB_ADDR_W-1:0]     addr;
        logic                       addr_oe;
        logic [`ARB_DATA_W-1:0]     dout;
        logic                       data_oe;
        logic [`ARB_CS_COUNT-1:0]   cs_n;
        logic                       as_n;
        logic                       rd_n;
        logic                       hwr_n;
        logic                       lwr_n;
        logic                       ctl_oe;
        logic                       narrow;
        logic                       done;
        logic [`ARB_DATA_W-1:0]     rdata;
    } arb_state_t;

    arb_state_t                 s_r;
    arb_state_t                 s_nxt;
    logic                       ext_bus_request_n_n_s;
    logic [`ARB_DATA_W-1:0]     data_in_s;
    logic                       release_wanted;

    // Area index from the top address bits
    function automatic logic [2:0] area_of(input logic [`ARB_ADDR_W-1:0] a);
        area_of = a[`ARB_AREA_MSB:`ARB_AREA_LSB];
    endfunction : area_of

    // One-hot active-low select for an address
    function automatic logic [`ARB_CS_COUNT-1:0] cs_decode(
        input logic [`ARB_ADDR_W-1:0] a);
        cs_decode = ~(`ARB_CS_COUNT'(1) << area_of(a));
    endfunction : cs_decode

    // Request pin and read data come from outside the clock domain
    pin_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_ext_bus_request_n_sync (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .pin_in   (ext_bus_request_n),
        .sync_out (ext_bus_request_n_n_s)
    );

    pin_sync #(.WIDTH(`ARB_DATA_W), .RESET_VAL('0)) u_data_sync (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .pin_in   (data_in),
        .sync_out (data_in_s)
    );

    // Release is honoured only in extended mode with the enable bit set
    assign release_wanted = ext_mode && release_enable_bit && !ext_bus_request_n_n_s;

    // Arbiter, release handshake and bus cycle engine in one next-state block
    always_comb
    begin
        s_nxt      = s_r;
        s_nxt.done = 1'b0;

        // Ownership: independent of release so internal work continues
        unique case (s_r.own)
            OWN_NONE:
            begin
                if (xfer_req)
                    s_nxt.own = OWN_XFER;
                else if (core_req)
                    s_nxt.own = OWN_CORE;
            end
            OWN_CORE:
            begin
                // Never pull the bus away mid-cycle or outside a yield point
                if (s_r.st == BUS_IDLE || s_r.st == BUS_RELEASED)
                begin
                    if (xfer_req && core_yield)
                        s_nxt.own = OWN_XFER;
                    else if (!core_req)
                        s_nxt.own = OWN_NONE;
                end
            end
            OWN_XFER:
            begin
                if ((s_r.st == BUS_IDLE || s_r.st == BUS_RELEASED)
                    && (!xfer_req || (core_req && xfer_yield)))
                    s_nxt.own = core_req ? OWN_CORE : OWN_NONE;
            end
            default:
                s_nxt.own = OWN_NONE;
        endcase
        // Only one acknowledge can stand, taken from the owner register
        s_nxt.core_ack = (s_nxt.own == OWN_CORE);
        s_nxt.xfer_ack = (s_nxt.own == OWN_XFER);

        unique case (s_r.st)
            BUS_IDLE:
            begin
                // Release checked before any cycle start
                if (release_wanted)
                begin
                    s_nxt.st      = BUS_RELEASED;
                    s_nxt.ack_n   = 1'b0;
                    s_nxt.addr_oe = 1'b0;
                    s_nxt.data_oe = 1'b0;
                    s_nxt.ctl_oe  = 1'b0;
                end
                else if (cyc_req && (s_r.core_ack || s_r.xfer_ack))
                begin
                    s_nxt.st      = BUS_T1;
                    s_nxt.narrow  = narrow_area_mask[area_of(cyc_addr)];
                    s_nxt.addr    = cyc_addr;
                    s_nxt.addr_oe = 1'b1;
                    s_nxt.ctl_oe  = 1'b1;
                    s_nxt.cs_n    = cs_decode(cyc_addr);
                    s_nxt.as_n    = 1'b0;
                    s_nxt.rd_n    = cyc_write;
                    if (narrow_area_mask[area_of(cyc_addr)])
                    begin
                        // Byte travels on the upper lane only
                        s_nxt.dout  = {cyc_wdata[7:0], 8'h00};
                        s_nxt.hwr_n = !cyc_write;
                        s_nxt.lwr_n = 1'b1;
                    end
                    else
                    begin
                        s_nxt.dout  = cyc_wdata;
                        s_nxt.hwr_n = !(cyc_write && cyc_be[`ARB_BE_UPPER]);
                        s_nxt.lwr_n = !(cyc_write && cyc_be[`ARB_BE_LOWER]);
                    end
                    s_nxt.data_oe = cyc_write;
                end
            end
            BUS_T1:
                // Second state follows with no wait state insertion
                s_nxt.st = BUS_T2;
            BUS_T2:
            begin
                s_nxt.st    = BUS_IDLE;
                s_nxt.done  = 1'b1;
                s_nxt.cs_n  = {`ARB_CS_COUNT{1'b1}};
                s_nxt.as_n  = 1'b1;
                s_nxt.rd_n  = 1'b1;
                s_nxt.hwr_n = 1'b1;
                s_nxt.lwr_n = 1'b1;
                s_nxt.data_oe = 1'b0;
                if (s_r.narrow)
                    s_nxt.rdata = {8'h00, data_in_s[`ARB_UPPER_MSB:`ARB_UPPER_LSB]};
                else
                    s_nxt.rdata = data_in_s;
            end
            BUS_RELEASED:
            begin
                // Pending cycles simply wait here until the request drops
                if (ext_bus_request_n_n_s)
                begin
                    s_nxt.st      = BUS_IDLE;
                    s_nxt.ack_n   = 1'b1;
                    s_nxt.addr_oe = 1'b1;
                    s_nxt.ctl_oe  = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_r          <= '0;
            s_r.st       <= BUS_IDLE;
            s_r.own      <= OWN_NONE;
            s_r.ack_n    <= 1'b1;
            s_r.addr_oe  <= 1'b1;
            s_r.ctl_oe   <= 1'b1;
            s_r.cs_n     <= {`ARB_CS_COUNT{1'b1}};
            s_r.as_n     <= 1'b1;
            s_r.rd_n     <= 1'b1;
            s_r.hwr_n    <= 1'b1;
            s_r.lwr_n    <= 1'b1;
        end
        else
            s_r <= s_nxt;
    end

    // All outputs straight from the state register
    assign core_ack             = s_r.core_ack;
    assign xfer_ack             = s_r.xfer_ack;
    assign cyc_done             = s_r.done;
    assign cyc_rdata            = s_r.rdata;
    assign ext_bus_ack_n        = s_r.ack_n;
    assign addr_out             = s_r.addr;
    assign addr_oe              = s_r.addr_oe;
    assign data_out             = s_r.dout;
    assign data_oe              = s_r.data_oe;
    assign chip_select_n        = s_r.cs_n;
    assign address_strobe_n     = s_r.as_n;
    assign read_strobe_n        = s_r.rd_n;
    assign upper_write_strobe_n = s_r.hwr_n;
    assign lower_write_strobe_n = s_r.lwr_n;
    assign ctl_oe               = s_r.ctl_oe;

    // Entry into release needs mode and enable in the cycle before
    a_release_gate: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (s_r.st == BUS_RELEASED && $past(s_r.st) == BUS_IDLE)
        |-> $past(ext_mode) && $past(release_enable_bit))
        else $error("bus released without enable");

    a_release_float: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (s_r.st == BUS_RELEASED)
        |-> !s_r.ack_n && !s_r.addr_oe && !s_r.data_oe && !s_r.ctl_oe)
        else $error("bus driven while released");

    a_internal_runs: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (s_r.st == BUS_RELEASED && s_r.own == OWN_NONE && xfer_req)
        |=> xfer_ack)
        else $error("internal grant blocked by release");

    a_cycle_deferred: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (s_r.st == BUS_RELEASED && !ext_bus_request_n_n_s) |=> (s_r.st == BUS_RELEASED) && !cyc_done)
        else $error("cycle started during release");

    a_release_ends: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (s_r.st == BUS_RELEASED && ext_bus_request_n_n_s) |=> s_r.ack_n && s_r.st == BUS_IDLE)
        else $error("release not ended");

    a_release_first: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (s_r.st == BUS_IDLE && release_wanted && cyc_req)
        |=> (s_r.st == BUS_RELEASED))
        else $error("access served before release");

    a_single_grant: assert property (@(posedge clk_sys) disable iff (!reset_n)
        !(core_ack && xfer_ack))
        else $error("two masters acknowledged");

    a_xfer_takes: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (s_r.own == OWN_CORE && xfer_req && core_yield && s_r.st == BUS_IDLE)
        |=> xfer_ack && !core_ack)
        else $error("transfer controller not granted");

    a_core_kept: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (core_ack && core_req && !core_yield) |=> core_ack)
        else $error("core preempted outside yield point");

    a_upper_lane: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (s_r.st == BUS_T1 && s_r.narrow) |-> s_r.lwr_n)
        else $error("lower lane used in narrow space");

    a_two_state: assert property (@(posedge clk_sys) disable iff (!reset_n)
        (s_r.st == BUS_T1) |=> (s_r.st == BUS_T2) ##1 cyc_done)
        else $error("cycle not two states");
endmodule : bus_mastership_arbiter

// ---- verification/ext_master_model.sv ----
/*
 Behavioural outside master that asks the device for the external bus.
 Assumes the bench raises want_bus just after a clock edge and holds it.
*/
`timescale 1ns/1ps
module ext_master_model
(
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic reset_n,
    // Wish from the bench
    input  wire logic want_bus,
    // Release handshake pins
    input  wire logic ext_bus_ack_n,
    output logic      ext_bus_request_n,
    output logic      owns_bus
);
    // Pin moves just after the edge, never on it, so the sampling is clean
    always @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            ext_bus_request_n <= 1'b1;
        else
            ext_bus_request_n <= #1 ~want_bus;
    end

    // Bus is ours only while both pins sit low
    assign owns_bus = ~ext_bus_request_n & ~ext_bus_ack_n;
endmodule : ext_master_model

// ---- verification/tb_top.sv ----
/*
 Self-checking bench: grants, handover, two-state cycles, bus release.
 Assumes the design, its package and ext_master_model are compiled first.
*/
`timescale 1ns/1ps
module tb_top
    import arb_pkg::*;
;
    // Clock, reset and configuration
    logic        clk_sys = 1'b0;
    logic        reset_n = 1'b0;
    logic        ext_mode = 1'b1, release_enable_bit = 1'b1;
    logic [7:0]  narrow_area_mask = 8'h04;
    // Internal masters and cycle request
    logic        core_req = 1'b0, core_yield = 1'b0, xfer_req = 1'b0, xfer_yield = 1'b0;
    logic        core_ack, xfer_ack, cyc_done, want_bus = 1'b0, owns_bus;
    logic        cyc_req = 1'b0, cyc_write = 1'b0;
    logic [1:0]  cyc_be = 2'b00;
    logic [23:0] cyc_addr = 24'h00_0000, addr_out;
    logic [15:0] cyc_wdata = 16'h0000, cyc_rdata, data_out, slave_data = 16'h0000;
    // Pins
    logic        ext_bus_request_n, ext_bus_ack_n, addr_oe, data_oe, ctl_oe;
    logic [7:0]  chip_select_n;
    logic        address_strobe_n, read_strobe_n, upper_write_strobe_n, lower_write_strobe_n;
    int          mismatches = 0, checks_done = 0;
    // Data pins resolve from whoever drives them
    wire logic [15:0] data_in = data_oe ? data_out : slave_data;

    always #5 clk_sys = ~clk_sys;

    bus_mastership_arbiter u_bus_mastership_arbiter (.clk_sys, .reset_n, .ext_mode,
        .release_enable_bit, .narrow_area_mask, .core_req, .core_yield, .xfer_req,
        .xfer_yield, .core_ack, .xfer_ack, .cyc_req, .cyc_write, .cyc_be, .cyc_addr,
        .cyc_wdata, .cyc_done, .cyc_rdata, .ext_bus_request_n, .ext_bus_ack_n, .addr_out,
        .addr_oe, .data_in, .data_out, .data_oe, .chip_select_n, .address_strobe_n,
        .read_strobe_n, .upper_write_strobe_n, .lower_write_strobe_n, .ctl_oe);

    ext_master_model u_ext_master_model (.clk_sys, .reset_n, .want_bus, .ext_bus_ack_n,
        .ext_bus_request_n, .owns_bus);

    // Inputs always move 1 ns after the rising edge
    task automatic step(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : step

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check

    task automatic test_done();
        $display("checks %0d, mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done

    // Signals that a bounded wait may watch; a code keeps the wait free of ref arguments
    localparam int W_CORE = 0, W_XFER = 1, W_BACK = 2, W_DONE = 3;

    function automatic logic watched(input int sel);
        case (sel)
            W_CORE:  watched = core_ack;
            W_XFER:  watched = xfer_ack;
            W_BACK:  watched = ext_bus_ack_n;
            default: watched = cyc_done;
        endcase
    endfunction : watched

    // Bounded wait; running out is a mismatch and ends the run
    task automatic wait_lvl(input int sel, input logic v, input int lim, input string what);
        int n = 0;
        while (watched(sel) !== v && n < lim)
        begin
            step(1);
            n++;
        end
        checks_done++;
        if (watched(sel) !== v)
        begin
            mismatches++;
            $display("wrong value %s: expected %b, seen timeout", what, v);
            test_done();
        end
    endtask : wait_lvl

    task automatic t_priority();
        core_req = 1'b1;
        xfer_req = 1'b1;
        step(2);
        check("xfer_ack", xfer_ack, 1);
        check("core_ack", core_ack, 0);
        // Transfer controller yields with its request still up
        xfer_yield = 1'b1;
        wait_lvl(W_CORE, 1'b1, 4, "core_ack");
        check("xfer_ack off", xfer_ack, 0);
        xfer_req = 1'b0;
        xfer_yield = 1'b0;
        step(1);
        check("core kept", core_ack, 1);
        $display("priority test done");
    endtask : t_priority

    task automatic t_handover();
        xfer_req = 1'b1;
        step(5);
        check("core keeps", {core_ack, xfer_ack}, 2'b10);
        core_yield = 1'b1;
        wait_lvl(W_XFER, 1'b1, 4, "xfer_ack");
        check("core_ack", core_ack, 0);
        xfer_req = 1'b0;
        core_yield = 1'b0;
        wait_lvl(W_CORE, 1'b1, 4, "core_ack back");
        $display("handover test done");
    endtask : t_handover

    // One two-state cycle; strobes are {as, rd, upper wr, lower wr}
    task automatic run_cycle(input logic w, input logic [1:0] be, input logic [23:0] a,
                             input logic [15:0] wd, input logic [3:0] st, input logic [7:0] cs,
                             input logic [15:0] dm, input logic [15:0] rd);
        cyc_write = w;
        cyc_be = be;
        cyc_addr = a;
        cyc_wdata = wd;
        cyc_req = 1'b1;
        step(1);
        check("addr_out", addr_out, a);
        check("strobes", {address_strobe_n, read_strobe_n, upper_write_strobe_n,
                          lower_write_strobe_n}, st);
        check("chip_select_n", chip_select_n, cs);
        check("data_out", data_out & dm, (w && dm == 16'hFF00) ? {wd[7:0], 8'h00} : wd & dm);
        check("data_oe", data_oe, w);
        step(2);
        check("cyc_done", cyc_done, 1);
        cyc_req = 1'b0;
        if (!w)
            check("cyc_rdata", cyc_rdata, rd);
        step(1);
        check("strobes idle", {address_strobe_n, read_strobe_n, upper_write_strobe_n,
                               lower_write_strobe_n}, 4'hF);
    endtask : run_cycle

    task automatic t_cycles();
        slave_data = 16'hC33C;
        run_cycle(1, 2'b01, 24'h20_0010, 16'h1234, 4'b0110, 8'hFD, 16'hFFFF, 0);
        run_cycle(1, 2'b10, 24'h20_0012, 16'hABCD, 4'b0101, 8'hFD, 16'hFFFF, 0);
        run_cycle(1, 2'b01, 24'h40_0020, 16'h00A5, 4'b0101, 8'hFB, 16'hFF00, 0);
        run_cycle(0, 2'b00, 24'h40_0030, 16'h0000, 4'b0011, 8'hFB, 16'h0000, 16'h00C3);
        $display("cycle test done");
    endtask : t_cycles

    task automatic t_release();
        int seen = 0;
        want_bus = 1'b1;
        wait_lvl(W_BACK, 1'b0, 8, "ext_bus_ack_n low");
        check("oe floated", {addr_oe, data_oe, ctl_oe}, 3'b000);
        // Core lets go, then a fresh grant must still be made while released
        core_req = 1'b0;
        step(1);
        check("core_ack released", core_ack, 0);
        xfer_req = 1'b1;
        wait_lvl(W_XFER, 1'b1, 4, "xfer_ack released");
        cyc_addr = 24'h20_0040;
        cyc_write = 1'b0;
        cyc_req = 1'b1;
        repeat (6)
        begin
            step(1);
            if (cyc_done === 1'b1)
                seen++;
        end
        check("held cycle", seen, 0);
        want_bus = 1'b0;
        wait_lvl(W_BACK, 1'b1, 8, "ext_bus_ack_n high");
        step(1);
        check("oe back", {addr_oe, ctl_oe}, 2'b11);
        wait_lvl(W_DONE, 1'b1, 6, "deferred cycle");
        cyc_req = 1'b0;
        xfer_req = 1'b0;
        core_req = 1'b1;
        step(3);
        $display("release test done");
    endtask : t_release

    task automatic t_refused();
        release_enable_bit = 1'b0;
        want_bus = 1'b1;
        step(8);
        check("no release disabled", {ext_bus_ack_n, addr_oe}, 2'b11);
        want_bus = 1'b0;
        ext_mode = 1'b0;
        release_enable_bit = 1'b1;
        step(4);
        want_bus = 1'b1;
        step(8);
        check("no release single chip", ext_bus_ack_n, 1);
        want_bus = 1'b0;
        step(4);
        ext_mode = 1'b1;
        $display("refusal test done");
    endtask : t_refused

    // Release request and cycle request meet at the same edge
    task automatic t_race();
        want_bus = 1'b1;
        step(3);
        cyc_addr = 24'h20_0050;
        cyc_req = 1'b1;
        check("sync delay", ext_bus_ack_n, 1);
        step(1);
        check("release first", {ext_bus_ack_n, ctl_oe}, 2'b00);
        want_bus = 1'b0;
        wait_lvl(W_BACK, 1'b1, 8, "race ack high");
        wait_lvl(W_DONE, 1'b1, 6, "race cycle");
        cyc_req = 1'b0;
        step(2);
        $display("race test done");
    endtask : t_race

    initial
    begin
        step(1);
        check("reset acks", {core_ack, xfer_ack, ext_bus_ack_n, cyc_done}, 4'b0010);
        check("reset oe", {addr_oe, ctl_oe, data_oe, chip_select_n}, 11'h6FF);
        step(2);
        reset_n = 1'b1;
        step(1);
        t_priority();
        t_handover();
        t_cycles();
        t_release();
        t_refused();
        t_race();
        test_done();
    end
endmodule : tb_top
